//--- include/lpsc_pkg.sv
// constants and types for the link power-state controller
package lpsc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned HPD_PROP_MAX_US = 100;
  localparam int unsigned HPD_DB_MIN_MS = 2;
  localparam int unsigned HPD_DB_MAX_MS = 4;
  localparam int unsigned IDLE_ENTRY_MAX_US = 300;
  localparam int unsigned SIG_GLITCH_ON_US = 25;
  localparam int unsigned SIG_GLITCH_OFF_NS = 50;
  localparam int unsigned EXIT_MAX_US = 200;
  localparam int unsigned EQ_3G_MAX_US = 700;
  localparam int unsigned EQ_HI_MAX_US = 500;

  // the debounce sits between min and max: use 3 ms
  localparam int unsigned HPD_DB_MS = (HPD_DB_MIN_MS + HPD_DB_MAX_MS) / 2;
  localparam int unsigned HPD_DB_CYC = HPD_DB_MS * (CLK_HZ / 1000);
  // glitch filter must outlast the widest glitch, so one cycle more
  localparam int unsigned SIG_ON_CYC = SIG_GLITCH_ON_US * (CLK_HZ / 1_000_000) + 1;
  localparam int unsigned SIG_OFF_NS_CYC = (SIG_GLITCH_OFF_NS * (CLK_HZ / 1_000_000)
                                            + 999) / 1000;
  localparam int unsigned SIG_OFF_CYC = (SIG_OFF_NS_CYC < 1 ? 1 : SIG_OFF_NS_CYC) + 1;
  localparam int unsigned EXIT_MAX_CYC = EXIT_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IDLE_MAX_CYC = IDLE_ENTRY_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HPD_PROP_CYC = HPD_PROP_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EQ_3G_CYC = EQ_3G_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EQ_HI_CYC = EQ_HI_MAX_US * (CLK_HZ / 1_000_000);

  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  typedef enum logic [1:0] {
    LPSC_POWERDOWN,
    LPSC_STANDBY,
    LPSC_EQ_ADAPT,
    LPSC_ACTIVE
  } lpsc_state_t;

  typedef struct packed {
    logic hot_plug;
    logic lane_signal;
    logic eq_done;
  } lpsc_sync_t;
endpackage

//--- design/lpsc_filter.sv
// glitch filter: output follows input only after it has been stable for a count
module lpsc_filter #(
  parameter int CNT_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic in_i,
  input wire logic [CNT_W-1:0] rise_cnt_i,
  input wire logic [CNT_W-1:0] fall_cnt_i,
  output logic out_o
);
  logic out_q, out_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    out_d = out_q;
    cnt_d = cnt_q;
    if (in_i == out_q) begin
      cnt_d = '0;
    end else if (cnt_q + 1'b1 >= (in_i ? rise_cnt_i : fall_cnt_i)) begin
      out_d = in_i;
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_q <= 1'b0;
      cnt_q <= '0;
    end else if (ce_i) begin
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign out_o = out_q;
endmodule

//--- design/lpsc_top.sv
// link power-state controller: powerdown, standby, active sequencing
module lpsc_top #(
  parameter int unsigned HPD_DB_CYC = lpsc_pkg::HPD_DB_CYC,
  parameter int unsigned EQ_3G_CYC = lpsc_pkg::EQ_3G_CYC,
  parameter int unsigned EQ_HI_CYC = lpsc_pkg::EQ_HI_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic ENABLE_PIN_I,
  input wire logic HOT_PLUG_IN_I,
  input wire logic LANE_SIGNAL_I,
  input wire logic EQ_OUTPUT_HOLD_OPTION_I,
  input wire logic RATE_3G_I,
  input wire logic EQ_DONE_I,
  output logic HOT_PLUG_OUT_O,
  output logic SIGNAL_PRESENT_OUT_O,
  output logic LANES_ENABLED_O,
  output logic EQ_START_O,
  output logic POWERDOWN_O,
  output logic STANDBY_O,
  output logic ACTIVE_O
);
  localparam logic [lpsc_pkg::CNT_W-1:0] DB_C = HPD_DB_CYC[lpsc_pkg::CNT_W-1:0];
  localparam logic [lpsc_pkg::CNT_W-1:0] ON_C = lpsc_pkg::SIG_ON_CYC[lpsc_pkg::CNT_W-1:0];
  localparam logic [lpsc_pkg::CNT_W-1:0] OFF_C = lpsc_pkg::SIG_OFF_CYC[lpsc_pkg::CNT_W-1:0];
  localparam logic [lpsc_pkg::CNT_W-1:0] EQ3_C = EQ_3G_CYC[lpsc_pkg::CNT_W-1:0];
  localparam logic [lpsc_pkg::CNT_W-1:0] EQH_C = EQ_HI_CYC[lpsc_pkg::CNT_W-1:0];

  // ----------------------------------------------------------------
  // reset and input synchronisers
  // ----------------------------------------------------------------
  logic en_m_q, en_q;
  logic rst_b;
  lpsc_pkg::lpsc_sync_t sm_q, sy_q;

  // enable pin is frozen with everything else while the clock enable is low
  always_ff @(posedge CLOCK_I) begin
    if (CE_I) begin
      en_m_q <= ENABLE_PIN_I;
      en_q <= en_m_q;
    end
  end
  assign rst_b = RST_B_I & en_q;

  always_ff @(posedge CLOCK_I) begin
    if (!rst_b) begin
      sm_q <= '0;
      sy_q <= '0;
    end else if (CE_I) begin
      sm_q <= '{HOT_PLUG_IN_I, LANE_SIGNAL_I, EQ_DONE_I};
      sy_q <= sm_q;
    end
  end

  // ----------------------------------------------------------------
  // filters
  // ----------------------------------------------------------------
  logic hpd_db, sig_db;

  // hot-plug filtered both ways with the same debounce
  lpsc_filter #(.CNT_W(lpsc_pkg::CNT_W)) u_hpd (
    .clk_i(CLOCK_I),
    .rst_b_i(rst_b),
    .ce_i(CE_I),
    .in_i(sy_q.hot_plug),
    .rise_cnt_i(DB_C),
    .fall_cnt_i(DB_C),
    .out_o(hpd_db)
  );

  lpsc_filter #(.CNT_W(lpsc_pkg::CNT_W)) u_sig (
    .clk_i(CLOCK_I),
    .rst_b_i(rst_b),
    .ce_i(CE_I),
    .in_i(sy_q.lane_signal),
    .rise_cnt_i(ON_C),
    .fall_cnt_i(OFF_C),
    .out_o(sig_db)
  );

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  lpsc_pkg::lpsc_state_t st_q, st_d;
  logic [lpsc_pkg::CNT_W-1:0] eq_cnt_q, eq_cnt_d;
  logic hpo_q, hpo_d;

  always_comb begin
    st_d = st_q;
    eq_cnt_d = lpsc_pkg::CNT_ZERO;
    hpo_d = sy_q.hot_plug;
    unique case (st_q)
      lpsc_pkg::LPSC_POWERDOWN: begin
        if (hpd_db) begin
          st_d = lpsc_pkg::LPSC_STANDBY;
        end
      end
      lpsc_pkg::LPSC_STANDBY: begin
        if (!hpd_db) begin
          st_d = lpsc_pkg::LPSC_POWERDOWN;
        end else if (sig_db) begin
          // hold option waits for equalization before going active
          st_d = EQ_OUTPUT_HOLD_OPTION_I ? lpsc_pkg::LPSC_EQ_ADAPT
                                         : lpsc_pkg::LPSC_ACTIVE;
        end
      end
      lpsc_pkg::LPSC_EQ_ADAPT: begin
        eq_cnt_d = eq_cnt_q + lpsc_pkg::CNT_ONE;
        if (!hpd_db) begin
          st_d = lpsc_pkg::LPSC_POWERDOWN;
        end else if (!sig_db) begin
          st_d = lpsc_pkg::LPSC_STANDBY;
        end else if (sy_q.eq_done || eq_cnt_d >= (RATE_3G_I ? EQ3_C : EQH_C)) begin
          st_d = lpsc_pkg::LPSC_ACTIVE;
        end
      end
      lpsc_pkg::LPSC_ACTIVE: begin
        if (!hpd_db) begin
          st_d = lpsc_pkg::LPSC_POWERDOWN;
        end else if (!sig_db) begin
          st_d = lpsc_pkg::LPSC_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!rst_b) begin
      st_q <= lpsc_pkg::LPSC_POWERDOWN;
      eq_cnt_q <= lpsc_pkg::CNT_ZERO;
      hpo_q <= 1'b0;
    end else if (CE_I) begin
      st_q <= st_d;
      eq_cnt_q <= eq_cnt_d;
      hpo_q <= hpo_d;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (!rst_b) begin
      HOT_PLUG_OUT_O <= 1'b0;
      SIGNAL_PRESENT_OUT_O <= 1'b0;
      LANES_ENABLED_O <= 1'b0;
      EQ_START_O <= 1'b0;
      POWERDOWN_O <= 1'b1;
      STANDBY_O <= 1'b0;
      ACTIVE_O <= 1'b0;
    end else if (CE_I) begin
      HOT_PLUG_OUT_O <= hpo_q;
      SIGNAL_PRESENT_OUT_O <= (st_d == lpsc_pkg::LPSC_ACTIVE);
      LANES_ENABLED_O <= (st_d == lpsc_pkg::LPSC_ACTIVE);
      EQ_START_O <= (st_d == lpsc_pkg::LPSC_EQ_ADAPT);
      POWERDOWN_O <= (st_d == lpsc_pkg::LPSC_POWERDOWN);
      STANDBY_O <= (st_d == lpsc_pkg::LPSC_STANDBY);
      ACTIVE_O <= (st_d == lpsc_pkg::LPSC_ACTIVE);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!rst_b || !CE_I);

  chk_hpd_follow: assert property ($changed(sy_q.hot_plug) |->
    ##2 HOT_PLUG_OUT_O == $past(sy_q.hot_plug, 2))
    else $error("hot plug output did not follow input");
  chk_pd_needs_low: assert property ($rose(POWERDOWN_O) |-> !sy_q.hot_plug || !hpd_db)
    else $error("powerdown entered with hot plug high");
  chk_sb_needs_high: assert property ($fell(POWERDOWN_O) |-> hpd_db)
    else $error("powerdown left without debounced hot plug");
  chk_idle_standby: assert property (ACTIVE_O && !sig_db && hpd_db |=> STANDBY_O)
    else $error("idle lanes did not enter standby");
  chk_short_glitch: assert property (STANDBY_O && $rose(sy_q.lane_signal)
    ##1 !sy_q.lane_signal |-> ##1 !ACTIVE_O)
    else $error("short glitch woke active state");
  chk_active_go: assert property (STANDBY_O && sig_db && hpd_db
    && !EQ_OUTPUT_HOLD_OPTION_I |=> ACTIVE_O)
    else $error("standby exit missed");
  chk_hold_eq: assert property (STANDBY_O && sig_db && hpd_db
    && EQ_OUTPUT_HOLD_OPTION_I |=> EQ_START_O)
    else $error("equalization hold not taken");
  chk_eq_bound: assert property (eq_cnt_q <= EQ3_C)
    else $error("equalization wait overran");
  chk_one_state: assert property ($onehot({POWERDOWN_O, STANDBY_O, EQ_START_O, ACTIVE_O}))
    else $error("state outputs not one-hot");

  cov_standby: cover property ($fell(POWERDOWN_O));
  cov_active: cover property ($rose(ACTIVE_O));
  cov_eq: cover property ($rose(EQ_START_O));
  cov_back_pd: cover property ($fell(ACTIVE_O) ##1 POWERDOWN_O);
endmodule

//--- sim/lpsc_src.sv
// link source model: hot-plug level, lane activity and equalization done
module lpsc_src (
  input wire logic clk_i,
  input wire logic eq_start_i,
  output logic hot_plug_o,
  output logic lane_o,
  output logic eq_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int eq_lat = 5;
  int eq_cnt = 0;
  initial begin
    hot_plug_o = 1'b0;
    lane_o = 1'b0;
    eq_done_o = 1'b0;
  end
  // done answers a start after eq_lat cycles, drops once start ends
  always @(posedge clk_i) begin
    eq_cnt <= eq_start_i ? eq_cnt + 1 : 0;
    eq_done_o <= #5 eq_start_i && (eq_cnt >= eq_lat);
  end
  // levels change just after an edge and are seen for cyc samples
  task automatic drive(input logic hpd, input logic lane, input int cyc);
    @(posedge clk_i);
    #5;
    hot_plug_o = hpd;
    lane_o = lane;
    repeat ((cyc > 0) ? cyc - 1 : 0) @(posedge clk_i);
  endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the link power-state controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DB = 20;
  localparam int EQ3 = 30;
  localparam int EQH = 20;
  localparam logic [5:0] PD = 6'h01;
  localparam logic [5:0] SB = 6'h02;
  localparam logic [5:0] EQ = 6'h04;
  localparam logic [5:0] ACT = 6'h38;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic en = 1'b0;
  logic hold = 1'b0;
  logic ce = 1'b1;
  logic r3g = 1'b1;
  logic hpd, lane, eqd, hpo, sig, lon, eqs, pd, sb, act;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 5;
  int cyc = 0;
  int n;
  always #25 clk = ~clk;
  // ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  lpsc_top #(.HPD_DB_CYC(DB), .EQ_3G_CYC(EQ3), .EQ_HI_CYC(EQH)) lpsc_top_i (
    .CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .ENABLE_PIN_I(en),
    .HOT_PLUG_IN_I(hpd), .LANE_SIGNAL_I(lane), .EQ_OUTPUT_HOLD_OPTION_I(hold),
    .RATE_3G_I(r3g), .EQ_DONE_I(eqd), .HOT_PLUG_OUT_O(hpo), .SIGNAL_PRESENT_OUT_O(sig),
    .LANES_ENABLED_O(lon), .EQ_START_O(eqs), .POWERDOWN_O(pd), .STANDBY_O(sb),
    .ACTIVE_O(act));
  lpsc_src lpsc_src_i (.clk_i(clk), .eq_start_i(eqs), .hot_plug_o(hpd), .lane_o(lane),
    .eq_done_o(eqd));
  // ----------------------------------------
  // checks and expectations
  // ----------------------------------------
  function automatic logic [5:0] st();
    return {sig, lon, act, eqs, sb, pd};
  endfunction
  function automatic int eq_bound(input logic fast3g);
    return (fast3g ? EQ3 : EQH) + 8;
  endfunction
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wait_st(input logic [5:0] exp, input int lo, input int hi);
    int k;
    k = 0;
    while (st() !== exp && k < hi) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(st(), exp);
    check(6'(k >= lo), 6'h01);
  endtask
  task automatic hold_st(input logic [5:0] exp, input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
      check(st(), exp);
    end
  endtask
  task automatic wait_hpo(input logic v);
    int k;
    for (k = 0; k < lpsc_pkg::HPD_PROP_CYC && hpo !== v; k++) begin
      @(posedge clk);
      #1;
    end
    check(6'(hpo), 6'(v));
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #5;
    check(st(), PD);
    rst_b = 1'b1;
    lpsc_src_i.drive(1'b1, 1'b0, DB + 10);
    hold_st(PD, DB + 12);
    lpsc_src_i.drive(1'b0, 1'b0, 10);
    #5;
    en = 1'b1;
    n = 1 + ($unsigned($random(seed)) % (DB - 4));
    lpsc_src_i.drive(1'b1, 1'b0, n);
    lpsc_src_i.drive(1'b0, 1'b0, 1);
    hold_st(PD, DB + 12);
    lpsc_src_i.drive(1'b1, 1'b0, 0);
    wait_hpo(1'b1);
    wait_st(SB, DB - 4, DB + 12);
    n = 1 + ($unsigned($random(seed)) % 500);
    lpsc_src_i.drive(1'b1, 1'b1, n);
    lpsc_src_i.drive(1'b1, 1'b0, 1);
    hold_st(SB, 520);
    lpsc_src_i.drive(1'b1, 1'b1, 0);
    wait_st(ACT, 490, lpsc_pkg::EXIT_MAX_CYC);
    lpsc_src_i.drive(1'b1, 1'b0, 1);
    lpsc_src_i.drive(1'b1, 1'b1, 0);
    hold_st(ACT, 20);
    lpsc_src_i.drive(1'b1, 1'b0, 0);
    wait_st(SB, 0, lpsc_pkg::IDLE_MAX_CYC);
    hold = 1'b1;
    repeat (3) begin
      r3g = $random(seed);
      lpsc_src_i.eq_lat = 1 + ($unsigned($random(seed)) % (EQH - 4));
      lpsc_src_i.drive(1'b1, 1'b1, 0);
      wait_st(EQ, 490, lpsc_pkg::EXIT_MAX_CYC);
      wait_st(ACT, lpsc_src_i.eq_lat, eq_bound(r3g));
      lpsc_src_i.drive(1'b1, 1'b0, 0);
      wait_st(SB, 0, lpsc_pkg::IDLE_MAX_CYC);
    end
    lpsc_src_i.drive(1'b1, 1'b1, 0);
    wait_st(ACT, 0, lpsc_pkg::EXIT_MAX_CYC + EQ3);
    n = 1 + ($unsigned($random(seed)) % (DB - 4));
    lpsc_src_i.drive(1'b0, 1'b1, n);
    lpsc_src_i.drive(1'b1, 1'b1, 1);
    hold_st(ACT, DB + 12);
    lpsc_src_i.drive(1'b0, 1'b1, 0);
    wait_hpo(1'b0);
    wait_st(PD, DB - 4, DB + 12);
    lpsc_src_i.drive(1'b1, 1'b0, 0);
    wait_st(SB, DB - 4, DB + 12);
    // clock enable low: a long hot-plug drop must not be seen
    #4;
    ce = 1'b0;
    lpsc_src_i.drive(1'b0, 1'b0, 1);
    hold_st(SB, DB + 12);
    lpsc_src_i.drive(1'b1, 1'b0, 0);
    hold_st(SB, 4);
    #4;
    ce = 1'b1;
    hold_st(SB, DB + 4);
    #4;
    en = 1'b0;
    wait_st(PD, 0, 8);
    stop_test();
  end
endmodule
